/* File: pcr_clock_output_pin_gen.sv */
// clock output divider driven by a reference tick at four times master clock
`timescale 1ns/1ps
module pcr_clock_output_pin_gen
  import pcr_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  pcr_clock_output_pin_if.gen lnk
);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic       pin_q;
  logic       pin_d;
  logic [3:0] term;
  logic       rate_ok;
  logic       fast_code;
  logic       run;
  logic       wrap;

  ////////////////////////////////////////////////////////////////////////////
  // half period select; codes 101, 110 and 111 all leave the pin low
  assign term = (lnk.rate_code == PCR_CLK_X2) ? PCR_HALF_X2 :
                (lnk.rate_code == PCR_CLK_X1) ? PCR_HALF_X1 :
                (lnk.rate_code == PCR_CLK_D2) ? PCR_HALF_D2 :
                (lnk.rate_code == PCR_CLK_D4) ? PCR_HALF_D4 : PCR_HALF_D8;
  assign rate_ok   = (lnk.rate_code <= PCR_CLK_D8);
  // the two fastest rates are not produced while pdm output runs
  assign fast_code = (lnk.rate_code <= PCR_CLK_X1);
  assign run       = rate_ok && !(lnk.pdm_active && fast_code);
  // compare with >= so a rate change to a shorter period never overruns
  assign wrap      = (cnt_q >= term);

  assign cnt_d = !run ? 4'h0 : !lnk.ref_tick ? cnt_q : wrap ? 4'h0 : cnt_q + 4'h1;
  assign pin_d = !run ? 1'b0 : (lnk.ref_tick && wrap) ? !pin_q : pin_q;

  // divider state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
      pin_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pin_q <= pin_d;
    end
  end

  assign lnk.pin = pin_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  off_code_low_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (lnk.rate_code == PCR_CLK_OFF) [*2] |-> !lnk.pin)
    else $error("clock output not low for off code");

  undef_code_low_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (lnk.rate_code == 3'h5 || lnk.rate_code == 3'h6) [*2] |-> !lnk.pin)
    else $error("clock output not low for undefined code");

  pdm_fast_low_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (lnk.pdm_active && lnk.rate_code <= PCR_CLK_X1) [*2] |-> !lnk.pin)
    else $error("fast clock output active during pdm");

  x2_toggle_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ((lnk.rate_code == PCR_CLK_X2 && !lnk.pdm_active) [*2] ##0 lnk.ref_tick)
    |=> (lnk.pin != $past(lnk.pin)))
    else $error("double rate output missed a toggle");

endmodule : pcr_clock_output_pin_gen

/* File: pcr_clock_output_pin_if.sv */
// link between the register block and the clock output divider
`timescale 1ns/1ps
interface pcr_clock_output_pin_if;
  logic [2:0] rate_code;
  logic       pdm_active;
  logic       ref_tick;
  logic       pin;

  modport ctl (output rate_code, output pdm_active, output ref_tick, input pin);
  modport gen (input rate_code, input pdm_active, input ref_tick, output pin);
endinterface : pcr_clock_output_pin_if

/* File: pcr_ctrl.sv */
// pll, clock output and regulator control registers behind an ahb-lite slave
//
// Notes on behaviour
// - the denominator low byte is a read/write byte at index 0x02, reset to zero.
// - the numerator high byte sits at 0x03 and low byte at 0x04, read/write, reset zero.
// - the integer multiplier is bits 6..3, codes 2..8 valid, 0 and 1 reserved.
// - the pin clock predivider is bits 2..1, codes 0..3 divide by 1..4.
// - bit 0 of index 0x05 picks integer (0) or fractional (1) pll mode.
// - bit 0 of index 0x06 is a read-only lock flag, reset 0, writes ignored.
// - bits 2..0 of index 0x07 set the clock output pin frequency.
// - codes 0..4 give master clock x2, x1, /2, /4, /8; code 7 holds the pin low.
// - the two fastest clock output rates need not run while pdm output is on.
// - bit 2 of index 0x08 powers the ldo regulator down when set.
// - bits 1..0 of index 0x08 pick 1.2 V (00) or 1.1 V (01); 10 and 11 reserved.
`timescale 1ns/1ps
module pcr_ctrl
  import pcr_pkg::*;
(
  input  wire  logic        clk,
  input  wire  logic        nrst,
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic        hreadyout,
  output logic [31:0] hrdata,
  output logic        hresp,
  input  wire  logic        pll_lock_in,
  input  wire  logic [1:0]  pulse_density_output_control,
  input  wire  logic        mclk_x4_tick,
  output logic [15:0] pll_denominator,
  output logic [15:0] pll_numerator,
  output logic [3:0]  pll_multiplier,
  output logic [1:0]  pll_predivide_code,
  output logic        pll_fractional,
  output logic        ldo_power_down,
  output logic [1:0]  ldo_voltage_select,
  output logic        multipurpose_clock_output_pin,
  output logic        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0]           cfg_q [PCR_NUM_CFG];
  logic [7:0]           cfg_d [PCR_NUM_CFG];
  logic                 wr_q;
  logic                 wr_d;
  logic [7:0]           idx_q;
  logic [7:0]           idx_d;
  logic [31:0]          rdata_q;
  logic [31:0]          rdata_d;
  logic [PCR_IRQ_W-1:0] stat_q;
  logic [PCR_IRQ_W-1:0] stat_d;
  logic [PCR_IRQ_W-1:0] ien_q;
  logic [PCR_IRQ_W-1:0] ien_d;
  logic                 addr_act;
  logic                 mapped;
  logic [7:0]           a_idx;
  logic                 wr_en;
  logic [7:0]           wbyte;
  logic [7:0]           rd_byte;
  logic                 lock_now;
  logic                 lock_rise;
  logic                 lock_fall;
  logic [PCR_IRQ_W-1:0] ev;
  logic [PCR_IRQ_W-1:0] clr;
  logic                 stat_rd;
  logic                 en_rd;
  logic [2:0]           rate_code;
  logic                 pdm_on;

  pcr_clock_output_pin_if clk_lnk ();

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase decode; registers sit at four times their index
  assign addr_act = hsel && hready && htrans[PCR_HTRANS_ACT];
  assign mapped   = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
  assign a_idx    = mapped ? haddr[9:2] : 8'h00;

  // zero wait state slave, every answer is okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // data phase write strobe; only the low byte lane is stored
  assign wr_d  = addr_act && hwrite;
  assign idx_d = addr_act ? a_idx : 8'h00;
  assign wr_en = wr_q;
  assign wbyte = hwdata[7:0];

  // address phase capture
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q  <= 1'b0;
      idx_q <= 8'h00;
    end else begin
      wr_q  <= wr_d;
      idx_q <= idx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration bytes, indices 1..8; lock bit comes from the pll, not the bus
  generate
    for (genvar k = 0; k < PCR_NUM_CFG; k++) begin : g_cfg
      localparam logic [7:0] IDX = 8'(k + 1);
      logic hit;
      logic bit0_w;
      assign hit = wr_en && (idx_q == IDX);
      assign bit0_w = hit ? wbyte[0] : cfg_q[k][0];
      if (IDX == PCR_IDX_LOCK) begin : g_lock
        // reserved bits stay writable, the flag tracks the pll only
        assign cfg_d[k] = {(hit ? wbyte[7:1] : cfg_q[k][7:1]), pll_lock_in};
      end else begin : g_plain
        assign cfg_d[k] = {(hit ? wbyte[7:1] : cfg_q[k][7:1]), bit0_w};
      end
    end
  endgenerate

  // configuration storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < PCR_NUM_CFG; i++) begin
        cfg_q[i] <= PCR_RST_BYTE;
      end
    end else begin
      for (int i = 0; i < PCR_NUM_CFG; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pll settings; the block does not police writes while the pll runs,
  // so a mid-run write reaches the pll at once
  assign pll_denominator    = {cfg_q[PCR_IDX_DEN_HI - 1], cfg_q[PCR_IDX_DEN_LO - 1]};
  assign pll_numerator      = {cfg_q[PCR_IDX_NUM_HI - 1], cfg_q[PCR_IDX_NUM_LO - 1]};
  // reserved multiplier codes 0 and 1 are passed through unchanged
  assign pll_multiplier     = cfg_q[PCR_IDX_INT_CFG - 1][PCR_MULT_MSB:PCR_MULT_LSB];
  assign pll_predivide_code = cfg_q[PCR_IDX_INT_CFG - 1][PCR_DIV_MSB:PCR_DIV_LSB];
  assign pll_fractional     = cfg_q[PCR_IDX_INT_CFG - 1][PCR_TYPE_BIT];

  // regulator controls; reserved voltage codes are passed through
  assign ldo_power_down     = cfg_q[PCR_IDX_LDO - 1][PCR_PD_BIT];
  assign ldo_voltage_select = cfg_q[PCR_IDX_LDO - 1][PCR_VSEL_MSB:0];

  ////////////////////////////////////////////////////////////////////////////
  // clock output divider
  assign rate_code          = cfg_q[PCR_IDX_CLOCK_OUTPUT_PIN - 1][PCR_RATE_MSB:0];
  assign pdm_on             = (pulse_density_output_control != 2'h0);
  assign clk_lnk.rate_code  = rate_code;
  assign clk_lnk.pdm_active = pdm_on;
  assign clk_lnk.ref_tick   = mclk_x4_tick;
  assign multipurpose_clock_output_pin = clk_lnk.pin;

  pcr_clock_output_pin_gen u_clock_output_pin (
    .clk  (clk),
    .nrst (nrst),
    .lnk  (clk_lnk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // lock edge events, sticky status, write-one-to-clear, enable mask
  assign lock_now  = cfg_q[PCR_IDX_LOCK - 1][PCR_LOCK_BIT];
  assign lock_rise = pll_lock_in && !lock_now;
  assign lock_fall = !pll_lock_in && lock_now;
  assign ev        = {lock_fall, lock_rise};
  assign clr       = (wr_en && idx_q == PCR_IDX_IRQ_CLR) ? wbyte[PCR_IRQ_W-1:0] : '0;
  // a new event in the clearing cycle wins over the clear
  assign stat_d    = (stat_q & ~clr) | ev;
  assign ien_d     = (wr_en && idx_q == PCR_IDX_IRQ_EN) ? wbyte[PCR_IRQ_W-1:0] : ien_q;
  assign irq       = |(stat_q & ien_q);

  // interrupt state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= PCR_RST_IRQ;
      ien_q  <= PCR_RST_IRQ;
    end else begin
      stat_q <= stat_d;
      ien_q  <= ien_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux in the address phase so hrdata comes from a flop in data phase;
  // unmapped and write-only addresses read zero
  assign stat_rd = (a_idx == PCR_IDX_IRQ_STAT);
  assign en_rd   = (a_idx == PCR_IDX_IRQ_EN);
  assign rd_byte = (a_idx >= PCR_IDX_DEN_HI && a_idx <= PCR_IDX_LDO) ?
                     cfg_q[3'(a_idx - 8'h01)] :
                   stat_rd ? {6'h00, stat_q} :
                   en_rd   ? {6'h00, ien_q}  : 8'h00;
  assign rdata_d = (addr_act && !hwrite) ? {24'h000000, rd_byte} : rdata_q;

  // read data register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  den_lo_write_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr_en && idx_q == PCR_IDX_DEN_LO)
    |=> (pll_denominator[7:0] == $past(hwdata[7:0])))
    else $error("denominator low byte not written");

  num_write_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr_en && idx_q == PCR_IDX_NUM_HI)
    |=> (pll_numerator[15:8] == $past(hwdata[7:0]))
        ##1 ((pll_numerator[15:8] == $past(hwdata[7:0], 2))
             || $past(wr_en && idx_q == PCR_IDX_NUM_HI)))
    else $error("numerator high byte not written or not held");

  num_lo_write_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr_en && idx_q == PCR_IDX_NUM_LO)
    |=> (pll_numerator[7:0] == $past(hwdata[7:0])))
    else $error("numerator low byte not written");

  int_cfg_fields_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr_en && idx_q == PCR_IDX_INT_CFG)
    |=> (pll_multiplier == $past(hwdata[6:3])
         && pll_predivide_code == $past(hwdata[2:1])
         && pll_fractional == $past(hwdata[0])))
    else $error("integer setting fields wrong");

  lock_flag_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ##1 (lock_now == $past(pll_lock_in)))
    else $error("lock flag does not follow pll");

  lock_read_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (addr_act && !hwrite && a_idx == PCR_IDX_LOCK)
    |=> (hrdata[0] == $past(pll_lock_in, 2) && hrdata[31:8] == 24'h000000))
    else $error("lock flag read back wrong");

  ldo_control_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr_en && idx_q == PCR_IDX_LDO)
    |=> (ldo_power_down == $past(hwdata[2])
         && ldo_voltage_select == $past(hwdata[1:0])))
    else $error("regulator control not written");

  rate_code_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr_en && idx_q == PCR_IDX_CLOCK_OUTPUT_PIN)
    |=> (clk_lnk.rate_code == $past(hwdata[2:0])))
    else $error("clock output code not written");

  rise_sets_irq_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (lock_rise && ien_q[PCR_IRQ_RISE] && !(wr_en && idx_q == PCR_IDX_IRQ_EN))
    |=> irq)
    else $error("lock rise did not raise interrupt");

  // zero wait states and an okay response on every cycle
  bus_okay_a: assert property (
    @(posedge clk) disable iff (!nrst)
    hreadyout && !hresp)
    else $error("slave stalled or answered with an error");

  // read data stands until the next read address phase
  rdata_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !(addr_act && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  // addresses past the enable register and the clear register read zero
  spare_read_zero_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (addr_act && !hwrite && a_idx > PCR_IDX_IRQ_EN) |=> (hrdata == 32'h00000000))
    else $error("unused address did not read zero");

  clr_read_zero_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (addr_act && !hwrite && a_idx == PCR_IDX_IRQ_CLR) |=> (hrdata == 32'h00000000))
    else $error("clear register did not read zero");

  // configuration outputs move only on a write to their own index
  den_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !(wr_en && (idx_q == PCR_IDX_DEN_HI || idx_q == PCR_IDX_DEN_LO))
    |=> $stable(pll_denominator))
    else $error("denominator changed without a write");

  num_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !(wr_en && (idx_q == PCR_IDX_NUM_HI || idx_q == PCR_IDX_NUM_LO))
    |=> $stable(pll_numerator))
    else $error("numerator changed without a write");

  int_cfg_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !(wr_en && idx_q == PCR_IDX_INT_CFG)
    |=> $stable({pll_multiplier, pll_predivide_code, pll_fractional}))
    else $error("integer settings changed without a write");

  ldo_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !(wr_en && idx_q == PCR_IDX_LDO)
    |=> $stable({ldo_power_down, ldo_voltage_select}))
    else $error("regulator control changed without a write");

  rate_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !(wr_en && idx_q == PCR_IDX_CLOCK_OUTPUT_PIN)
    |=> $stable(clk_lnk.rate_code))
    else $error("clock output code changed without a write");

  // status bits stay set until cleared, and an event always sets its bit
  stat_sticky_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ##1 (($past(stat_q & ~clr) & ~stat_q) == '0))
    else $error("status bit lost without a clear");

  ev_sets_stat_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ##1 (($past(ev) & ~stat_q) == '0))
    else $error("lock event did not set its status bit");

  ien_write_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr_en && idx_q == PCR_IDX_IRQ_EN) |=> (ien_q == $past(wbyte[PCR_IRQ_W-1:0])))
    else $error("interrupt enable not written");

endmodule : pcr_ctrl

/* File: pcr_pkg.sv */
// constants for the pll, clock output and regulator control block
package pcr_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] PCR_IDX_DEN_HI   = 8'h01;
  localparam logic [7:0] PCR_IDX_DEN_LO   = 8'h02;
  localparam logic [7:0] PCR_IDX_NUM_HI   = 8'h03;
  localparam logic [7:0] PCR_IDX_NUM_LO   = 8'h04;
  localparam logic [7:0] PCR_IDX_INT_CFG  = 8'h05;
  localparam logic [7:0] PCR_IDX_LOCK     = 8'h06;
  localparam logic [7:0] PCR_IDX_CLOCK_OUTPUT_PIN   = 8'h07;
  localparam logic [7:0] PCR_IDX_LDO      = 8'h08;
  localparam logic [7:0] PCR_IDX_IRQ_STAT = 8'h10;
  localparam logic [7:0] PCR_IDX_IRQ_CLR  = 8'h11;
  localparam logic [7:0] PCR_IDX_IRQ_EN   = 8'h12;
  localparam int         PCR_NUM_CFG      = 8;

  // reset values
  localparam logic [7:0] PCR_RST_BYTE = 8'h00;
  localparam logic [1:0] PCR_RST_IRQ  = 2'h0;

  // field positions
  localparam int PCR_MULT_MSB = 6;
  localparam int PCR_MULT_LSB = 3;
  localparam int PCR_DIV_MSB  = 2;
  localparam int PCR_DIV_LSB  = 1;
  localparam int PCR_TYPE_BIT = 0;
  localparam int PCR_LOCK_BIT = 0;
  localparam int PCR_RATE_MSB = 2;
  localparam int PCR_PD_BIT   = 2;
  localparam int PCR_VSEL_MSB = 1;

  // interrupt status bits
  localparam int PCR_IRQ_RISE = 0;
  localparam int PCR_IRQ_FALL = 1;
  localparam int PCR_IRQ_W    = 2;

  // clock output rate codes
  localparam logic [2:0] PCR_CLK_X2  = 3'h0;
  localparam logic [2:0] PCR_CLK_X1  = 3'h1;
  localparam logic [2:0] PCR_CLK_D2  = 3'h2;
  localparam logic [2:0] PCR_CLK_D4  = 3'h3;
  localparam logic [2:0] PCR_CLK_D8  = 3'h4;
  localparam logic [2:0] PCR_CLK_OFF = 3'h7;

  // reference ticks per half period, less one, for each rate code
  localparam logic [3:0] PCR_HALF_X2 = 4'h0;
  localparam logic [3:0] PCR_HALF_X1 = 4'h1;
  localparam logic [3:0] PCR_HALF_D2 = 4'h3;
  localparam logic [3:0] PCR_HALF_D4 = 4'h7;
  localparam logic [3:0] PCR_HALF_D8 = 4'hf;

  // ahb transfer type bit that marks an active transfer
  localparam int PCR_HTRANS_ACT = 1;

endpackage : pcr_pkg

/* File: tb_top.sv */
// self-checking bench for the pll, clock output and regulator control block
`timescale 1ns/1ps
module tb_top
  import pcr_pkg::*;
;

  logic        clk;
  logic        nrst;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic        lock_in;
  logic        tick;
  logic        tick_en;
  logic        pin;
  logic        irq;
  logic        ldo_pd;
  logic        frac;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0]  htrans;
  logic [1:0]  pdm;
  logic [1:0]  prediv;
  logic [1:0]  vsel;
  logic [2:0]  hsize;
  logic [15:0] den;
  logic [15:0] num;
  logic [3:0]  mult;
  int          num_errors;
  int          n_compared;

  // hready loops back from the single slave
  pcr_ctrl u_dut (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pll_lock_in(lock_in),
    .pulse_density_output_control(pdm), .mclk_x4_tick(tick),
    .pll_denominator(den), .pll_numerator(num), .pll_multiplier(mult),
    .pll_predivide_code(prediv), .pll_fractional(frac), .ldo_power_down(ldo_pd),
    .ldo_voltage_select(vsel), .multipurpose_clock_output_pin(pin), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock and reference tick, one tick every second cycle
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    tick <= tick_en & ~tick;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // waits as long as the slave needs; only the watchdog ends a stuck wait
  task automatic wait_rdy;
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
  endtask : wait_rdy

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  task automatic chk(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    cmp(rd, exp);
  endtask : chk

  task automatic wait_pin(input logic v, inout int n);
    while (pin !== v && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_pin

  // rise-to-rise period in clocks, or pin held low when exp is zero
  task automatic meas(input logic [2:0] code, input int exp);
    int n;
    int t0;
    int hi;
    n = 0;
    hi = 0;
    wr(PCR_IDX_CLOCK_OUTPUT_PIN, {29'h0, code});
    if (exp == 0) begin
      repeat (3) @(negedge clk);
      repeat (80) begin
        @(negedge clk);
        if (pin !== 1'b0) hi++;
      end
      cmp(32'(hi), 32'h0);
    end else begin
      wait_pin(1'b0, n);
      wait_pin(1'b1, n);
      t0 = n;
      wait_pin(1'b0, n);
      wait_pin(1'b1, n);
      cmp(32'(n - t0), 32'(exp));
    end
  endtask : meas

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    for (int i = 1; i <= 8; i++) begin
      chk(8'(i), 32'h0);
    end
    cmp({den, num}, 32'h0);
    cmp({20'h0, hresp, irq, ldo_pd, vsel, mult, prediv, frac}, 32'h0);
    wr(8'h20, 32'h77);
    chk(8'h20, 32'h0);
  endtask : t_reset

  // upper data bits are dropped, only the byte lane is stored
  task automatic t_ratio;
    wr(PCR_IDX_DEN_HI, 32'ha5);
    wr(PCR_IDX_DEN_LO, 32'hffff_ff5a);
    wr(PCR_IDX_NUM_HI, 32'hc3);
    wr(PCR_IDX_NUM_LO, 32'h3c);
    @(negedge clk);
    cmp({16'h0, den}, 32'ha55a);
    cmp({16'h0, num}, 32'hc33c);
    chk(PCR_IDX_DEN_LO, 32'h5a);
    chk(PCR_IDX_NUM_HI, 32'hc3);
  endtask : t_ratio

  task automatic t_intcfg;
    logic [7:0] v;
    for (int m = 0; m <= 8; m++) begin
      v = {1'b1, 4'(m), 2'(m), 1'(m)};
      wr(PCR_IDX_INT_CFG, {24'h0, v});
      @(negedge clk);
      cmp({25'h0, mult, prediv, frac}, {25'h0, v[6:0]});
      chk(PCR_IDX_INT_CFG, {24'h0, v});
    end
  endtask : t_intcfg

  task automatic t_ldo;
    for (int v = 0; v < 8; v++) begin
      wr(PCR_IDX_LDO, 32'(v) | 32'hf8);
      @(negedge clk);
      cmp({29'h0, ldo_pd, vsel}, 32'(v));
      chk(PCR_IDX_LDO, 32'(v) | 32'hf8);
    end
  endtask : t_ldo

  // lock flag ignores writes, then raises and drops the interrupt
  task automatic t_lock;
    wr(PCR_IDX_LOCK, 32'hff);
    chk(PCR_IDX_LOCK, 32'hfe);
    @(posedge clk);
    lock_in <= 1'b1;
    repeat (3) @(posedge clk);
    chk(PCR_IDX_LOCK, 32'hff);
    chk(PCR_IDX_IRQ_STAT, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    wr(PCR_IDX_IRQ_EN, 32'h3);
    @(negedge clk);
    cmp({31'h0, irq}, 32'h1);
    wr(PCR_IDX_IRQ_CLR, 32'h1);
    @(negedge clk);
    cmp({31'h0, irq}, 32'h0);
    chk(PCR_IDX_IRQ_STAT, 32'h0);
    chk(PCR_IDX_IRQ_CLR, 32'h0);
    chk(PCR_IDX_IRQ_EN, 32'h3);
    @(posedge clk);
    lock_in <= 1'b0;
    repeat (3) @(posedge clk);
    chk(PCR_IDX_IRQ_STAT, 32'h2);
    cmp({31'h0, irq}, 32'h1);
    wr(PCR_IDX_IRQ_CLR, 32'h2);
    @(negedge clk);
    cmp({31'h0, irq}, 32'h0);
  endtask : t_lock

  task automatic t_clk;
    for (int c = 0; c < 8; c++) begin
      meas(3'(c), (c < 5) ? (4 << c) : 0);
    end
    @(posedge clk);
    pdm <= 2'h1;
    meas(PCR_CLK_X2, 0);
    meas(PCR_CLK_D2, 16);
    @(posedge clk);
    pdm <= 2'h3;
    meas(PCR_CLK_X1, 0);
    @(posedge clk);
    pdm <= 2'h2;
    meas(PCR_CLK_X2, 0);
    @(posedge clk);
    pdm <= 2'h0;
    meas(PCR_CLK_X1, 8);
  endtask : t_clk

  ////////////////////////////////////////////////////////////////////////////////
  // run control
  task automatic wrap_up;
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    lock_in = 1'b0;
    pdm = 2'h0;
    tick_en = 1'b0;
    num_errors = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    tick_en <= 1'b1;
    t_reset();
    t_ratio();
    t_intcfg();
    t_ldo();
    t_lock();
    t_clk();
    wrap_up();
  end

  // the whole run needs just under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
endmodule : tb_top
